// ==== cwf_regs.svh ====
/*
 * Register map, field positions, widths, mode codes and timing constants
 * of the complementary waveform generator.
 * Assumes a 32-bit APB slave with 8-bit byte addresses, one word per register.
 */
`ifndef CWF_REGS_SVH
`define CWF_REGS_SVH

// byte offsets
`define CWF_OFS_MAIN 8'h00
`define CWF_OFS_POL 8'h04
`define CWF_OFS_CLK 8'h08
`define CWF_OFS_INSEL 8'h0C
`define CWF_OFS_DBR 8'h10
`define CWF_OFS_DBF 8'h14
`define CWF_OFS_SD 8'h18
`define CWF_OFS_SDSRC 8'h1C
`define CWF_OFS_STEER 8'h20
`define CWF_OFS_STAT 8'h24

// main control fields
`define CWF_MAIN_EN 7
`define CWF_MAIN_LD 6
// dead-band register enable bit
`define CWF_DB_EN 7
// shutdown control fields
`define CWF_SD_SW 7
`define CWF_SD_AREN 6

// widths and counts
`define CWF_DB_W 6
`define CWF_NSRC 14
`define CWF_NSD 4
`define CWF_NSYNC 18
`define CWF_ACC_W 7

// timebase figures, MHz
`define CWF_SYS_CLK_MHZ 7'd100
`define CWF_OSC_MHZ 7'd16

// mode codes
`define CWF_MODE_ASTEER 3'h0
`define CWF_MODE_SSTEER 3'h1
`define CWF_MODE_FWD 3'h2
`define CWF_MODE_REV 3'h3
`define CWF_MODE_HALF 3'h4
`define CWF_MODE_PP 3'h5

`endif

// ==== cwf_pkg.sv ====
/*
 * Types of the complementary waveform generator: mode and
 * push-pull sequencer enumerations and the packed state record.
 * Assumes cwf_regs.svh is on the include path.
 */
`include "cwf_regs.svh"

package cwf_pkg;

    typedef enum logic [2:0] {
        CWF_ASTEER = `CWF_MODE_ASTEER,
        CWF_SSTEER = `CWF_MODE_SSTEER,
        CWF_FWD = `CWF_MODE_FWD,
        CWF_REV = `CWF_MODE_REV,
        CWF_HALF = `CWF_MODE_HALF,
        CWF_PP = `CWF_MODE_PP,
        CWF_RSV6 = 3'h6,
        CWF_RSV7 = 3'h7
    } cwf_mode_t;

    // gray coded along the A, gap, B, gap cycle
    typedef enum logic [1:0] {
        CWF_PP_WAIT_A = 2'h0,
        CWF_PP_ON_A = 2'h1,
        CWF_PP_WAIT_B = 2'h3,
        CWF_PP_ON_B = 2'h2
    } cwf_pp_t;

    typedef struct packed {
        logic en;
        logic ld;
        cwf_mode_t mode;
        logic [3:0] pol;
        logic clk_sel;
        logic [3:0] isel;
        logic [`CWF_DB_W:0] dbr_buf;
        logic [`CWF_DB_W:0] dbf_buf;
        logic [`CWF_DB_W-1:0] dbr;
        logic [`CWF_DB_W-1:0] dbf;
        logic sd_sw;
        logic auto_rst;
        logic [3:0] ovr;
        logic [`CWF_NSD-1:0] sd_src_en;
        logic [3:0] str;
        logic [3:0] str_lvl;
        logic [3:0] str_eff;
        logic [`CWF_NSYNC-1:0] sync1;
        logic [`CWF_NSYNC-1:0] sync2;
        logic [`CWF_NSYNC-1:0] sync3;
        logic [`CWF_NSYNC-1:0] filt;
        logic d_prev;
        logic [`CWF_DB_W-1:0] rcnt;
        logic [`CWF_DB_W-1:0] fcnt;
        logic [`CWF_DB_W-1:0] fbcnt;
        logic fb_hold;
        logic dir;
        cwf_pp_t pp;
        logic [`CWF_ACC_W-1:0] acc;
        logic [3:0] out;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cwf_state_t;

endpackage

// ==== cwf_core.sv ====
/*
 * Complementary waveform generator with APB register access.
 * Holds input selection, half-bridge, push-pull, full-bridge and
 * steering output logic, dead-band timers and auto-shutdown.
 * Assumes src_i and sd_n_i are asynchronous pins; APB on clk_sys_i.
 */
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ns
`include "cwf_regs.svh"

module cwf_core #(
    parameter int DB_W = `CWF_DB_W,
    parameter int NSRC = `CWF_NSRC
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // modulating sources and shutdown inputs
    input wire logic [NSRC-1:0] src_i,
    input wire logic [`CWF_NSD-1:0] sd_n_i,
    // waveform outputs
    output logic drive_out_a_o,
    output logic drive_out_b_o,
    output logic drive_out_c_o,
    output logic drive_out_d_o
);

    generate
        if (DB_W != `CWF_DB_W || NSRC != `CWF_NSRC) begin : g_bad_param
            $error("cwf_core: DB_W and NSRC must keep their documented values");
        end
    endgenerate

    cwf_pkg::cwf_state_t s_reg;
    cwf_pkg::cwf_state_t s_next;

    // sources idle low, shutdown inputs idle high: no false edge out of reset
    localparam logic [`CWF_NSYNC-1:0] SYNC_IDLE = {{`CWF_NSD{1'b1}}, {`CWF_NSRC{1'b0}}};

    // picks one of the synchronised sources; codes past the list read low
    function automatic logic sel_src(input logic [`CWF_NSRC-1:0] v, input logic [3:0] sel);
        logic r;
        r = 1'b0;
        if (sel < 4'(`CWF_NSRC)) begin
            r = v[sel];
        end
        return r;
    endfunction

    // active level to pin level: polarity set means active-high
    function automatic logic [3:0] apply_pol(input logic [3:0] act, input logic [3:0] pol);
        return act ^ ~pol;
    endfunction

    // dead-band counter step, saturating at the target
    function automatic logic [`CWF_DB_W-1:0] db_step(input logic [`CWF_DB_W-1:0] c,
                                                     input logic [`CWF_DB_W-1:0] tgt,
                                                     input logic tk);
        logic [`CWF_DB_W-1:0] r;
        r = c;
        if (tk && c < tgt) begin
            r = c + `CWF_DB_W'(1);
        end
        return r;
    endfunction

    logic d;
    logic rise;
    logic fall;
    logic tick;
    logic ext_sd;
    logic sd_act;
    logic wr;
    logic rd_setup;
    logic [3:0] act;
    logic [3:0] pin;
    logic [`CWF_DB_W-1:0] hold_tgt;
    logic hold_en;
    logic [`CWF_ACC_W-1:0] acc_sum;
    logic hit;
    logic [31:0] rdata;

    always_comb begin
        s_next = s_reg;
        act = 4'h0;
        pin = 4'h0;
        rdata = 32'h0;
        hit = 1'b1;

        // three-stage sync, value taken once stages two and three agree
        s_next.sync1 = {sd_n_i, src_i};
        s_next.sync2 = s_reg.sync1;
        s_next.sync3 = s_reg.sync2;
        s_next.filt = (s_reg.filt & (s_reg.sync2 ^ s_reg.sync3))
                    | (s_reg.sync3 & ~(s_reg.sync2 ^ s_reg.sync3));

        d = sel_src(s_reg.filt[`CWF_NSRC-1:0], s_reg.isel);
        rise = d & ~s_reg.d_prev;
        fall = ~d & s_reg.d_prev;
        s_next.d_prev = d;

        // clock select timebase
        // oscillator rate is modelled as a fractional tick from the system clock
        acc_sum = s_reg.acc + `CWF_OSC_MHZ;
        if (acc_sum >= `CWF_SYS_CLK_MHZ) begin
            s_next.acc = acc_sum - `CWF_SYS_CLK_MHZ;
        end else begin
            s_next.acc = acc_sum;
        end
        tick = s_reg.clk_sel ? (acc_sum >= `CWF_SYS_CLK_MHZ) : 1'b1;

        ext_sd = |(s_reg.sd_src_en & ~s_reg.filt[`CWF_NSYNC-1:`CWF_NSRC]);
        sd_act = s_reg.sd_sw | ext_sd;

        // apb: one wait-free access phase after each setup
        rd_setup = psel_i & ~penable_i;
        wr = psel_i & penable_i & pwrite_i & s_reg.pready;
        s_next.pready = rd_setup;
        case (paddr_i)
            `CWF_OFS_MAIN: begin
                rdata = {24'h0, s_reg.en, s_reg.ld, 3'h0, s_reg.mode};
            end
            `CWF_OFS_POL: begin
                rdata = {28'h0, s_reg.pol};
            end
            `CWF_OFS_CLK: begin
                rdata = {31'h0, s_reg.clk_sel};
            end
            `CWF_OFS_INSEL: begin
                rdata = {28'h0, s_reg.isel};
            end
            `CWF_OFS_DBR: begin
                rdata = {24'h0, s_reg.dbr_buf[DB_W], 1'b0, s_reg.dbr_buf[DB_W-1:0]};
            end
            `CWF_OFS_DBF: begin
                rdata = {24'h0, s_reg.dbf_buf[DB_W], 1'b0, s_reg.dbf_buf[DB_W-1:0]};
            end
            `CWF_OFS_SD: begin
                rdata = {24'h0, s_reg.sd_sw, s_reg.auto_rst, 2'h0, s_reg.ovr};
            end
            `CWF_OFS_SDSRC: begin
                rdata = {28'h0, s_reg.sd_src_en};
            end
            `CWF_OFS_STEER: begin
                rdata = {24'h0, s_reg.str_lvl, s_reg.str};
            end
            `CWF_OFS_STAT: begin
                rdata = {24'h0, s_reg.dir, ext_sd, sd_act, d, s_reg.out};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        if (rd_setup) begin
            s_next.prdata = pwrite_i ? 32'h0 : rdata;
            s_next.pslverr = ~hit;
        end

        if (wr && hit) begin
            case (paddr_i)
                `CWF_OFS_MAIN: begin
                    s_next.en = pwdata_i[`CWF_MAIN_EN];
                    s_next.ld = pwdata_i[`CWF_MAIN_LD];
                    s_next.mode = cwf_pkg::cwf_mode_t'(pwdata_i[2:0]);
                end
                `CWF_OFS_POL: begin
                    s_next.pol = pwdata_i[3:0];
                end
                `CWF_OFS_CLK: begin
                    s_next.clk_sel = pwdata_i[0];
                end
                `CWF_OFS_INSEL: begin
                    s_next.isel = pwdata_i[3:0];
                end
                `CWF_OFS_DBR: begin
                    s_next.dbr_buf = {pwdata_i[`CWF_DB_EN], pwdata_i[DB_W-1:0]};
                    if (!s_reg.en) begin
                        s_next.dbr = pwdata_i[DB_W-1:0];
                    end
                end
                `CWF_OFS_DBF: begin
                    s_next.dbf_buf = {pwdata_i[`CWF_DB_EN], pwdata_i[DB_W-1:0]};
                    if (!s_reg.en) begin
                        s_next.dbf = pwdata_i[DB_W-1:0];
                    end
                end
                `CWF_OFS_SD: begin
                    s_next.sd_sw = pwdata_i[`CWF_SD_SW];
                    s_next.auto_rst = pwdata_i[`CWF_SD_AREN];
                    s_next.ovr = pwdata_i[3:0];
                end
                `CWF_OFS_SDSRC: begin
                    s_next.sd_src_en = pwdata_i[`CWF_NSD-1:0];
                end
                `CWF_OFS_STEER: begin
                    s_next.str = pwdata_i[3:0];
                    s_next.str_lvl = pwdata_i[7:4];
                end
                default: begin
                end
            endcase
        end

        if (s_reg.auto_rst && rise && !ext_sd) begin
            s_next.sd_sw = 1'b0;
        end
        // external fault sets the bit and wins over any clear
        if (ext_sd) begin
            s_next.sd_sw = 1'b1;
        end

        // buffered dead-band values load at falling input edge
        if (s_reg.en && s_reg.ld && fall) begin
            s_next.dbr = s_reg.dbr_buf[DB_W-1:0];
            s_next.dbf = s_reg.dbf_buf[DB_W-1:0];
            s_next.ld = 1'b0;
        end

        // count zero up to register value
        s_next.rcnt = d ? db_step(s_reg.rcnt, s_reg.dbr, tick) : '0;
        s_next.fcnt = d ? '0 : db_step(s_reg.fcnt, s_reg.dbf, tick);

        // full-bridge dead band on direction change
        hold_tgt = s_reg.dir ? s_reg.dbr : s_reg.dbf;
        hold_en = s_reg.dir ? s_reg.dbr_buf[DB_W] : s_reg.dbf_buf[DB_W];
        if (s_reg.fb_hold) begin
            s_next.fbcnt = db_step(s_reg.fbcnt, hold_tgt, tick);
            if (!hold_en || s_reg.fbcnt == hold_tgt) begin
                s_next.fb_hold = 1'b0;
            end
        end
        if ((s_reg.mode == cwf_pkg::CWF_FWD || s_reg.mode == cwf_pkg::CWF_REV)
            && rise && s_reg.mode[0] != s_reg.dir) begin
            s_next.dir = s_reg.mode[0];
            s_next.fb_hold = 1'b1;
            s_next.fbcnt = '0;
        end

        case (s_reg.pp)
            cwf_pkg::CWF_PP_WAIT_A: begin
                if (rise) begin
                    s_next.pp = cwf_pkg::CWF_PP_ON_A;
                end
            end
            cwf_pkg::CWF_PP_ON_A: begin
                if (fall) begin
                    s_next.pp = cwf_pkg::CWF_PP_WAIT_B;
                end
            end
            cwf_pkg::CWF_PP_WAIT_B: begin
                if (rise) begin
                    s_next.pp = cwf_pkg::CWF_PP_ON_B;
                end
            end
            cwf_pkg::CWF_PP_ON_B: begin
                if (fall) begin
                    s_next.pp = cwf_pkg::CWF_PP_WAIT_A;
                end
            end
            default: begin
                s_next.pp = cwf_pkg::CWF_PP_WAIT_A;
            end
        endcase
        if (!s_reg.en || sd_act) begin
            s_next.pp = cwf_pkg::CWF_PP_WAIT_A;
        end

        if (s_reg.mode == cwf_pkg::CWF_ASTEER || rise) begin
            s_next.str_eff = s_reg.str;
        end

        case (s_reg.mode)
            cwf_pkg::CWF_HALF: begin
                // true and inverted with dead band
                act[0] = d & (~s_reg.dbr_buf[DB_W] | s_reg.rcnt == s_reg.dbr);
                act[1] = ~d & (~s_reg.dbf_buf[DB_W] | s_reg.fcnt == s_reg.dbf);
                // C and D follow A and B
                act[2] = act[0];
                act[3] = act[1];
            end
            cwf_pkg::CWF_PP: begin
                act[0] = s_next.pp == cwf_pkg::CWF_PP_ON_A;
                act[1] = s_next.pp == cwf_pkg::CWF_PP_ON_B;
                // C copies A, D copies B
                act[2] = act[0];
                act[3] = act[1];
            end
            cwf_pkg::CWF_FWD, cwf_pkg::CWF_REV: begin
                if (s_next.dir) begin
                    act = {1'b0, 1'b1, d & ~s_next.fb_hold, 1'b0};
                end else begin
                    act = {d & ~s_next.fb_hold, 1'b0, 1'b0, 1'b1};
                end
            end
            default: begin
                act = {4{d}};
            end
        endcase

        pin = apply_pol(act, s_reg.pol);
        if (sd_act) begin
            pin = s_reg.ovr;
        end
        if (s_reg.mode == cwf_pkg::CWF_ASTEER || s_reg.mode == cwf_pkg::CWF_SSTEER) begin
            // shutdown touches only steered pins
            for (int i = 0; i < 4; i++) begin
                pin[i] = s_next.str_eff[i] ? pin[i] : s_reg.str_lvl[i];
            end
        end
        s_next.out = pin;

        if (!s_reg.en) begin
            s_next.out = apply_pol(4'h0, s_reg.pol);
            s_next.rcnt = '0;
            s_next.fcnt = '0;
            s_next.fbcnt = '0;
            s_next.fb_hold = 1'b0;
            s_next.dir = s_reg.mode[0];
            s_next.str_eff = s_reg.str;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg <= '0;
            // reset polarity clear: outputs rest high (inactive, active-low)
            s_reg.out <= 4'hF;
            s_reg.filt <= SYNC_IDLE;
            s_reg.sync1 <= SYNC_IDLE;
            s_reg.sync2 <= SYNC_IDLE;
            s_reg.sync3 <= SYNC_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata_o = s_reg.prdata;
    assign pready_o = s_reg.pready;
    assign pslverr_o = s_reg.pslverr;
    assign drive_out_a_o = s_reg.out[0];
    assign drive_out_b_o = s_reg.out[1];
    assign drive_out_c_o = s_reg.out[2];
    assign drive_out_d_o = s_reg.out[3];

endmodule

// ==== cwf_core_props.sv ====
/* checker for the waveform generator ports: apb answers and output levels.
   assumes it is bound into cwf_core and that register writes land at pready. */
`timescale 1ns/1ns
`include "cwf_regs.svh"
module cwf_core_props #(
    parameter int NSRC = 14
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // pins
    input wire logic [NSRC-1:0] src_i,
    input wire logic [`CWF_NSD-1:0] sd_n_i,
    input wire logic drive_out_a_o,
    input wire logic drive_out_b_o,
    input wire logic drive_out_c_o,
    input wire logic drive_out_d_o
);
    logic en_reg, sd_reg, wr, ext;
    logic [2:0] mode_reg;
    logic [3:0] pol_reg, ovr_reg, sde_reg, cfg_reg, sq_reg, outs;
    logic [`CWF_NSD-1:0] sdp_reg;
    logic [NSRC-1:0] srcp_reg;
    logic [3:0] isel_reg;
    logic stale_reg, selp_reg, sel;
    assign sel = isel_reg < NSRC && src_i[isel_reg];
    assign wr = psel_i && penable_i && pready_o && pwrite_i;
    assign ext = |(~sd_n_i & sde_reg);
    assign outs = {drive_out_a_o, drive_out_b_o, drive_out_c_o, drive_out_d_o};
    // shadow of the control registers, quiet counters saturate at 15
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {en_reg, sd_reg, mode_reg, pol_reg, ovr_reg, sde_reg} <= '0;
            {cfg_reg, sq_reg, sdp_reg, srcp_reg, isel_reg, stale_reg, selp_reg} <= '0;
        end else begin
            sdp_reg <= sd_n_i;
            srcp_reg <= src_i;
            selp_reg <= sel;
            if (wr && paddr_i == `CWF_OFS_MAIN) stale_reg <= 1'b1;
            else if (sel && !selp_reg) stale_reg <= 1'b0;
            if (wr && paddr_i == `CWF_OFS_INSEL) isel_reg <= pwdata_i[3:0];
            cfg_reg <= (wr || sd_n_i != sdp_reg) ? 4'h0 : cfg_reg + {3'h0, cfg_reg != 4'hF};
            sq_reg <= (src_i != srcp_reg) ? 4'h0 : sq_reg + {3'h0, sq_reg != 4'hF};
            if (ext) begin
                sd_reg <= 1'b1;
            end else if (wr && paddr_i == `CWF_OFS_SD) begin
                sd_reg <= pwdata_i[7];
            end
            if (wr && paddr_i == `CWF_OFS_MAIN) begin
                en_reg <= pwdata_i[7];
                mode_reg <= pwdata_i[2:0];
            end
            if (wr && paddr_i == `CWF_OFS_POL) pol_reg <= pwdata_i[3:0];
            if (wr && paddr_i == `CWF_OFS_SD) ovr_reg <= pwdata_i[3:0];
            if (wr && paddr_i == `CWF_OFS_SDSRC) sde_reg <= pwdata_i[3:0];
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    a_ready_follows: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_ready_idle: assert property (!psel_i |=> !pready_o)
        else $error("ready without request");
    a_err_unmapped: assert property (pready_o && paddr_i > `CWF_OFS_STAT
        |-> pslverr_o && (pwrite_i || prdata_o == 32'h0)) else $error("unmapped not refused");
    a_read_upper: assert property (pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h0)
        else $error("upper read bits set");
    a_off_inactive: assert property (
        !en_reg && !sd_reg && cfg_reg == 4'hF && (pol_reg == 4'h0 || pol_reg == 4'hF)
        |-> outs == ~pol_reg) else $error("disabled outputs not inactive");
    a_sd_override: assert property (
        en_reg && mode_reg[2:1] != 2'h0 && ext && cfg_reg == 4'hF
        && (ovr_reg == 4'h0 || ovr_reg == 4'hF) |-> outs == ovr_reg)
        else $error("override levels not applied");
    a_half_no_overlap: assert property (
        en_reg && mode_reg == `CWF_MODE_HALF && pol_reg == 4'hF && !sd_reg && cfg_reg == 4'hF
        |-> !(drive_out_a_o && drive_out_b_o)) else $error("half bridge overlap");
    a_fwd_b_off: assert property (
        en_reg && mode_reg == `CWF_MODE_FWD && pol_reg == 4'hF && !sd_reg && !stale_reg
        && cfg_reg == 4'hF && sq_reg == 4'hF |-> !drive_out_b_o) else $error("forward b active");
    a_rev_d_off: assert property (
        en_reg && mode_reg == `CWF_MODE_REV && pol_reg == 4'hF && !sd_reg && !stale_reg
        && cfg_reg == 4'hF && sq_reg == 4'hF |-> !drive_out_d_o) else $error("reverse d active");
    c_half: cover property (en_reg && mode_reg == `CWF_MODE_HALF && drive_out_b_o);
    c_rev: cover property (en_reg && mode_reg == `CWF_MODE_REV && drive_out_c_o);
    c_sd: cover property (en_reg && ext && cfg_reg == 4'hF);
endmodule

bind cwf_core cwf_core_props #(.NSRC(NSRC)) u_props (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .src_i(src_i), .sd_n_i(sd_n_i), .drive_out_a_o(drive_out_a_o),
    .drive_out_b_o(drive_out_b_o), .drive_out_c_o(drive_out_c_o),
    .drive_out_d_o(drive_out_d_o));

// ==== cwf_load.sv ====
/* switch driver load at the a and b outputs: counts turn-on events.
   assumes active-high drive and a clear from the bench. */
`timescale 1ns/1ns
module cwf_load (
    // clock and clear
    input wire logic clk_sys_i,
    input wire logic clr_i,
    // drive inputs
    input wire logic drive_a_i,
    input wire logic drive_b_i,
    // turn-on counts
    output logic [7:0] pulse_a_o,
    output logic [7:0] pulse_b_o
);
    logic pa_reg, pb_reg;
    always_ff @(posedge clk_sys_i) begin
        pa_reg <= drive_a_i;
        pb_reg <= drive_b_i;
        if (clr_i) begin
            pulse_a_o <= 8'h00;
            pulse_b_o <= 8'h00;
        end else begin
            pulse_a_o <= pulse_a_o + {7'h00, drive_a_i && !pa_reg};
            pulse_b_o <= pulse_b_o + {7'h00, drive_b_i && !pb_reg};
        end
    end
endmodule

// ==== tb.sv ====
/* self-checking bench of the waveform generator over apb.
   assumes zero-wait apb and about five clocks from input to outputs. */
`timescale 1ns/1ns
`include "cwf_regs.svh"
module tb;
    logic clk_sys_i, arst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err, clr;
    logic [7:0] paddr_i, pa, pb;
    logic [31:0] pwdata_i, prdata_o, rd, v;
    logic [13:0] src_i;
    logic [3:0] sd_n_i, outs;
    logic a, b, c, d;
    int n_fail, n_compared, i, j, m;
    logic [7:0] rb_adr [7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20};
    logic [7:0] rb_msk [7] = '{8'h0F, 8'h01, 8'h0F, 8'hBF, 8'hBF, 8'h0F, 8'hFF};
    int modes [4] = '{4, 5, 2, 3};
    assign outs = {a, b, c, d};
    cwf_core uut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .src_i(src_i),
        .sd_n_i(sd_n_i), .drive_out_a_o(a), .drive_out_b_o(b), .drive_out_c_o(c),
        .drive_out_d_o(d));
    cwf_load u_load (.clk_sys_i(clk_sys_i), .clr_i(clr), .drive_a_i(a), .drive_b_i(b),
        .pulse_a_o(pa), .pulse_b_o(pb));
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] adr, input logic [31:0] dat);
        int k;
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= adr;
        pwdata_i <= dat;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_sys_i);
            if (pready_o === 1'b1) break;
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (k == 20) begin
            n_fail++;
            $display("Error at %0t: no apb answer", $time);
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        apb(1'b1, adr, dat);
        check({31'h0, err}, 32'h0);
    endtask
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input logic xe);
        apb(1'b0, adr, 32'h0);
        check(rd, exp);
        check({31'h0, err}, {31'h0, xe});
    endtask
    // new levels, then longer than the input-to-output latency
    task automatic drive(input logic [13:0] s, input logic [3:0] sd);
        @(posedge clk_sys_i);
        src_i <= s;
        sd_n_i <= sd;
        repeat (16) @(posedge clk_sys_i);
    endtask
    function automatic logic [3:0] model(input int mode, input logic x);
        case (mode)
            4: return {x, !x, x, !x};
            2: return {1'b1, 1'b0, 1'b0, x};
            3: return {1'b0, x, 1'b1, 1'b0};
            default: return {4{x}};
        endcase
    endfunction
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        n_fail++;
        $display("Error at %0t: run too long", $time);
        report_and_stop();
    end
    initial begin
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, src_i} = '0;
        sd_n_i = 4'hF;
        clr = 1'b1;
        arst_n_i = 1'b0;
        n_fail = 0;
        n_compared = 0;
        v = $urandom(32'hA530);
        repeat (3) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        clr <= 1'b0;
        for (i = 0; i < 9; i++) rd_chk(8'(i * 4), 32'h0, 1'b0);
        check({28'h0, outs}, 32'hF);
        rd_chk(8'h40, 32'h0, 1'b1);
        for (i = 0; i < 7; i++) begin
            v = $urandom();
            wr(rb_adr[i], v);
            rd_chk(rb_adr[i], v & {24'h0, rb_msk[i]}, 1'b0);
            wr(rb_adr[i], 32'h0);
        end
        $display("registers done");
        wr(`CWF_OFS_POL, 32'hF);
        wr(`CWF_OFS_MAIN, 32'h84);
        for (i = 0; i < 16; i++) begin
            wr(`CWF_OFS_INSEL, 32'(i));
            for (j = 1; j >= 0; j--) begin
                v = $urandom();
                if (i < 14) v[i] = j[0];
                drive(v[13:0], 4'hF);
                check({28'h0, outs}, {28'h0, model(4, i < 14 && j == 1)});
            end
        end
        wr(`CWF_OFS_INSEL, 32'h0);
        wr(`CWF_OFS_POL, 32'h0);
        drive(14'h1, 4'hF);
        check({28'h0, outs}, {28'h0, ~model(4, 1'b1)});
        $display("half bridge done");
        wr(`CWF_OFS_SDSRC, 32'h1);
        wr(`CWF_OFS_SD, 32'hF);
        for (i = 0; i < 4; i++) begin
            wr(`CWF_OFS_MAIN, 32'h80 | 32'(modes[i]));
            drive(14'h1, 4'hE);
            check({28'h0, outs}, 32'hF);
        end
        drive(14'h1, 4'hF);
        wr(`CWF_OFS_SD, 32'hF);
        wr(`CWF_OFS_MAIN, 32'h84);
        drive(14'h1, 4'hF);
        check({28'h0, outs}, {28'h0, ~model(4, 1'b1)});
        $display("shutdown done");
        wr(`CWF_OFS_POL, 32'hF);
        drive(14'h0, 4'hF);
        wr(`CWF_OFS_MAIN, 32'h82);
        for (m = 2; m < 4; m++) begin
            // only the direction bit changes on the second pass
            if (m == 3) wr(`CWF_OFS_MAIN, 32'h83);
            drive(14'h1, 4'hF);
            check({28'h0, outs}, {28'h0, model(m, 1'b1)});
            drive(14'h0, 4'hF);
            check({28'h0, outs}, {28'h0, model(m, 1'b0)});
        end
        $display("full bridge done");
        wr(`CWF_OFS_MAIN, 32'h0);
        clr <= 1'b1;
        wr(`CWF_OFS_MAIN, 32'h85);
        clr <= 1'b0;
        drive(14'h1, 4'hF);
        check({28'h0, outs}, 32'hA);
        for (i = 0; i < 5; i++) drive(14'(i[0] ? 1 : 0), 4'hF);
        check({24'h0, pa, pb}, 32'h0201);
        wr(`CWF_OFS_MAIN, 32'h0);
        wr(`CWF_OFS_MAIN, 32'h85);
        drive(14'h1, 4'hF);
        check({24'h0, pa, pb}, 32'h0301);
        $display("push pull done");
        drive(14'h0, 4'hF);
        wr(`CWF_OFS_STEER, 32'hF);
        wr(`CWF_OFS_MAIN, 32'h81);
        drive(14'h1, 4'hF);
        check({28'h0, outs}, 32'hF);
        wr(`CWF_OFS_STEER, 32'h0);
        drive(14'h1, 4'hF);
        check({28'h0, outs}, 32'hF);
        drive(14'h0, 4'hF);
        drive(14'h1, 4'hF);
        check({28'h0, outs}, 32'h0);
        wr(`CWF_OFS_MAIN, 32'h80);
        wr(`CWF_OFS_STEER, 32'hF);
        drive(14'h1, 4'hF);
        check({28'h0, outs}, 32'hF);
        wr(`CWF_OFS_MAIN, 32'h0);
        drive(14'h1, 4'hF);
        check({28'h0, outs}, 32'h0);
        $display("steering done");
        wr(`CWF_OFS_DBR, 32'hBF);
        drive(14'h0, 4'hF);
        wr(`CWF_OFS_MAIN, 32'h84);
        drive(14'h1, 4'hF);
        check({28'h0, outs}, 32'h0);
        repeat (4) drive(14'h1, 4'hF);
        check({28'h0, outs}, 32'hA);
        wr(`CWF_OFS_CLK, 32'h1);
        drive(14'h0, 4'hF);
        repeat (5) drive(14'h1, 4'hF);
        check({28'h0, outs}, 32'h0);
        wr(`CWF_OFS_SD, 32'hCF);
        drive(14'h0, 4'hF);
        check({28'h0, outs}, 32'hF);
        drive(14'h1, 4'hF);
        check({28'h0, outs}, 32'h0);
        $display("dead band done");
        report_and_stop();
    end
endmodule
